// *** ifd_pkg.sv ***
package ifd_pkg;

  localparam int WORD_W = 16;
  localparam int UA_W   = 11;

  // field positions use the word's own numbering: bit 0 is the leftmost
  localparam int F_LEAD_A = 0;
  localparam int F_LEAD_B = 3;
  localparam int F_SUB2_A = 4;
  localparam int F_SUB2_B = 7;
  localparam int F_SUB1_A = 5;
  localparam int F_SUB1_B = 9;
  localparam int F_MINI_A = 8;
  localparam int F_MINI_B = 11;
  localparam int F_XBIT   = 4;
  localparam int F_CNT_A  = 10;
  localparam int F_CNT_B  = 15;
  localparam int F_DIR    = 10;
  localparam int F_DISP_A = 11;
  localparam int F_DISP_B = 15;
  localparam int F_MOVE_A = 8;
  localparam int F_MOVE_B = 10;
  localparam int F_BASE   = 11;
  localparam int F_SPD_A  = 14;
  localparam int F_SPD_B  = 15;
  localparam int F_SPEC_X = 15;
  localparam int F_IMM_A  = 8;
  localparam int F_IMM_B  = 15;
  localparam int F_SOPA_A = 4;
  localparam int F_SOPA_B = 9;
  localparam int F_SOPB_A = 10;
  localparam int F_SOPB_B = 15;

  localparam logic [3:0] LEAD_STACK = 4'h0;
  localparam logic [3:0] LEAD_SUB1  = 4'h1;
  localparam logic [3:0] LEAD_SUB2  = 4'h2;
  localparam logic [3:0] LEAD_SUB3  = 4'h3;
  localparam logic [3:0] SUB_MINI   = 4'h0;
  localparam logic [15:0] MOVE_MINI_MAP = 16'h00FF;

  localparam logic [UA_W-1:0] UPC_RESET   = 11'h000;
  localparam logic [UA_W-1:0] MINI_OFFSET = 11'h010;
  localparam logic [UA_W-1:0] LUT_BASE [16] = '{
    11'h000, 11'h040, 11'h060, 11'h080, 11'h0A0, 11'h0A1, 11'h0A2, 11'h0A3,
    11'h0A4, 11'h0A5, 11'h0A6, 11'h0A7, 11'h0A8, 11'h0A9, 11'h0AA, 11'h0AB};

  function automatic int dbit(input int n);
    return WORD_W - 1 - n;
  endfunction

  typedef enum logic [2:0] {
    GRP_STACK, GRP_SUB1, GRP_SUB2, GRP_SUB3, GRP_DIRECT
  } ifd_grp_t;

  typedef struct packed {
    ifd_grp_t        grp;
    logic [3:0]      lead;
    logic [4:0]      sub;
    logic            mini_en;
    logic [3:0]      mini;
    logic            xbit;
    logic [5:0]      cnt;
    logic            disp_neg;
    logic [4:0]      disp;
    logic            move_sel;
    logic [2:0]      move_code;
    logic            base_data;
    logic [1:0]      sp_dec;
    logic [4:0]      special;
    logic [3:0]      imm_op;
    logic [7:0]      imm;
    logic [5:0]      sop_a;
    logic [5:0]      sop_b;
    logic [UA_W-1:0] addr_a;
    logic [UA_W-1:0] addr_b;
  } ifd_fields_t;

endpackage

// *** ifd_dec_if.sv ***
`timescale 1ns/1ps
interface ifd_dec_if;
  logic [15:0]         word;
  ifd_pkg::ifd_fields_t f;

  modport producer (input word, output f);
  modport consumer (output word, input f);
endinterface

// *** ifd_field_decode.sv ***
`timescale 1ns/1ps
module ifd_field_decode (
  ifd_dec_if.producer dec
);

  logic [15:0]                w;
  logic [ifd_pkg::UA_W-1:0]   base;
  ifd_pkg::ifd_fields_t       f;

  assign w = dec.word;

  always_comb begin
    f = '0;
    f.lead = w[ifd_pkg::dbit(ifd_pkg::F_LEAD_A):
               ifd_pkg::dbit(ifd_pkg::F_LEAD_B)];
    base   = ifd_pkg::LUT_BASE[f.lead];
    f.mini = w[ifd_pkg::dbit(ifd_pkg::F_MINI_A):
               ifd_pkg::dbit(ifd_pkg::F_MINI_B)];
    f.xbit = w[ifd_pkg::dbit(ifd_pkg::F_XBIT)];
    f.cnt  = w[ifd_pkg::dbit(ifd_pkg::F_CNT_A):
               ifd_pkg::dbit(ifd_pkg::F_CNT_B)];
    f.disp_neg = w[ifd_pkg::dbit(ifd_pkg::F_DIR)];
    f.disp = w[ifd_pkg::dbit(ifd_pkg::F_DISP_A):
               ifd_pkg::dbit(ifd_pkg::F_DISP_B)];
    f.move_code =
      w[ifd_pkg::dbit(ifd_pkg::F_MOVE_A):ifd_pkg::dbit(ifd_pkg::F_MOVE_B)];
    f.base_data = w[ifd_pkg::dbit(ifd_pkg::F_BASE)];
    f.sp_dec = w[ifd_pkg::dbit(ifd_pkg::F_SPD_A):
                 ifd_pkg::dbit(ifd_pkg::F_SPD_B)];
    f.special = {f.mini, w[ifd_pkg::dbit(ifd_pkg::F_SPEC_X)]};
    f.imm_op = w[ifd_pkg::dbit(ifd_pkg::F_SUB2_A):
                 ifd_pkg::dbit(ifd_pkg::F_SUB2_B)];
    f.imm  = w[ifd_pkg::dbit(ifd_pkg::F_IMM_A):
               ifd_pkg::dbit(ifd_pkg::F_IMM_B)];
    f.sop_a = w[ifd_pkg::dbit(ifd_pkg::F_SOPA_A):
                ifd_pkg::dbit(ifd_pkg::F_SOPA_B)];
    f.sop_b = w[ifd_pkg::dbit(ifd_pkg::F_SOPB_A):
                ifd_pkg::dbit(ifd_pkg::F_SOPB_B)];
    f.addr_a = base;
    f.addr_b = base;
    unique case (f.lead)
      ifd_pkg::LEAD_STACK: begin
        f.grp    = ifd_pkg::GRP_STACK;
        f.addr_a = base + ifd_pkg::UA_W'(f.sop_a);
        f.addr_b = base + ifd_pkg::UA_W'(f.sop_b);
      end
      ifd_pkg::LEAD_SUB1: begin
        f.grp    = ifd_pkg::GRP_SUB1;
        f.sub    = w[ifd_pkg::dbit(ifd_pkg::F_SUB1_A):
                     ifd_pkg::dbit(ifd_pkg::F_SUB1_B)];
        f.addr_a = base + ifd_pkg::UA_W'(f.sub);
      end
      ifd_pkg::LEAD_SUB2, ifd_pkg::LEAD_SUB3: begin
        f.grp     = (f.lead == ifd_pkg::LEAD_SUB2) ? ifd_pkg::GRP_SUB2
                                                   : ifd_pkg::GRP_SUB3;
        f.sub     = {1'b0, f.imm_op};
        f.mini_en = (f.imm_op == ifd_pkg::SUB_MINI);
        f.move_sel = f.mini_en && (f.lead == ifd_pkg::LEAD_SUB2) &&
                     ifd_pkg::MOVE_MINI_MAP[f.mini];
        f.addr_a  = f.mini_en
                  ? base + ifd_pkg::MINI_OFFSET + ifd_pkg::UA_W'(f.mini)
                  : base + ifd_pkg::UA_W'(f.imm_op);
      end
      default: f.grp = ifd_pkg::GRP_DIRECT;
    endcase
  end

  assign dec.f = f;

endmodule // ifd_field_decode

// *** ifd_decoder.sv ***
`timescale 1ns/1ps
// Operation
// - every instruction gets its own start address from table and logic.
// - microprogram address register takes the start, then increments.
// - leading four bits decode first: one direct instruction or a group.
// - sub-opcode from bits 4-7 (groups 2,3), 5-9 (group 1), rest (stack).
// - some sub-opcodes enable a mini or special opcode in bits 8-11.
// - leading zero nibble is a stack word with two six-bit stack codes.
// - left stack op runs first; interrupt may be taken between the two.
// - leading 0001 selects group 1: shift, branch, bit test by bits 5-9.
// - shift count is the low six bits, plus index register if bit 4 set.
// - group 1 branch bit 4 marks indirect when one, direct when zero.
// - branch displacement is five bits from P; bit 10 gives sign.
// - bit test position is the low six bits, indexed when bit 4 set.
// - leading 0010 is group 2; sub-opcode 0000 moves coded in bits 8-10.
// - bit 11 selects program base (0) or data base (1) source.
// - move bits 12,13 ignored; two low bits give stack pointer decrement.
// - specials under group 2 sub 0000 use bits 8-11 and 15.
// - immediates in groups 2 and 3: bits 4-7 operation, low byte operand.
// - fetched word waits in next register until current one finishes.
module ifd_decoder (
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     fetch_valid_i,
  input  wire logic [15:0]              fetch_word_i,
  output logic                          fetch_ready_o,
  input  wire logic                     exec_done_i,
  input  wire logic                     upc_step_i,
  input  wire logic                     irq_pending_i,
  input  wire logic                     irq_done_i,
  output logic                          irq_window_o,
  output logic [15:0]                   cur_instr_o,
  output logic                          cur_valid_o,
  output logic                          start_load_o,
  output logic [ifd_pkg::UA_W-1:0]      upc_o,
  output logic                          stack_phase_b_o,
  output logic [5:0]                    active_stack_op_o,
  output ifd_pkg::ifd_grp_t             group_o,
  output logic [3:0]                    lead_o,
  output logic [4:0]                    sub_opcode_o,
  output logic                          mini_en_o,
  output logic [3:0]                    mini_opcode_o,
  output logic                          index_o,
  output logic                          indirect_o,
  output logic [5:0]                    count_o,
  output logic                          disp_neg_o,
  output logic [4:0]                    disp_o,
  output logic                          move_sel_o,
  output logic [2:0]                    move_code_o,
  output logic                          base_data_o,
  output logic [1:0]                    sp_dec_o,
  output logic [4:0]                    special_o,
  output logic [3:0]                    imm_op_o,
  output logic [7:0]                    imm_operand_o
);

  typedef enum logic [1:0] {
    ST_EMPTY, ST_RUN_A, ST_IRQ, ST_RUN_B
  } ifd_state_t;

  ifd_state_t                  state_q;
  ifd_state_t                  state_d;
  logic [15:0]                 next_instruction_holding_register_q;
  logic                        next_full_q;
  logic [15:0]                 current_instruction_holding_register_q;
  logic [ifd_pkg::UA_W-1:0]    microprogram_address_register_q;
  logic [ifd_pkg::UA_W-1:0]    addr_b_q;
  ifd_pkg::ifd_fields_t        dec_q;
  logic                        start_load_q;
  logic [5:0]                  active_op_q;
  logic                        accept;
  logic                        finish;
  logic                        half_done;
  logic                        take_cur;
  logic                        go_b;
  logic                        running;

  ifd_dec_if dec_bus ();

  ifd_field_decode u_fields (
    .dec (dec_bus.producer)
  );

  // decoding the waiting word lets the current fields load as flops
  assign dec_bus.word = next_instruction_holding_register_q;

  assign running   = (state_q == ST_RUN_A) || (state_q == ST_RUN_B);
  assign half_done = (state_q == ST_RUN_A) && exec_done_i &&
                     (dec_q.grp == ifd_pkg::GRP_STACK);
  assign finish    = exec_done_i && ((state_q == ST_RUN_B) ||
                     ((state_q == ST_RUN_A) &&
                      (dec_q.grp != ifd_pkg::GRP_STACK)));
  // the next word moves up only once the present one is done
  assign take_cur  = next_full_q &&
                     ((state_q == ST_EMPTY) || finish);
  assign go_b      = (half_done && !irq_pending_i) ||
                     ((state_q == ST_IRQ) && irq_done_i);
  assign accept    = fetch_valid_i && !next_full_q;

  assign fetch_ready_o = !next_full_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_EMPTY: if (take_cur) state_d = ST_RUN_A;
      ST_RUN_A: begin
        if (half_done) begin
          state_d = irq_pending_i ? ST_IRQ : ST_RUN_B;
        end else if (finish) begin
          state_d = take_cur ? ST_RUN_A : ST_EMPTY;
        end
      end
      ST_IRQ: if (irq_done_i) state_d = ST_RUN_B;
      ST_RUN_B: begin
        if (finish) begin
          state_d = take_cur ? ST_RUN_A : ST_EMPTY;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_EMPTY;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      next_instruction_holding_register_q <= 16'h0000;
      next_full_q                         <= 1'b0;
    end else begin
      if (accept) begin
        next_instruction_holding_register_q <= fetch_word_i;
      end
      if (accept) begin
        next_full_q <= 1'b1;
      end else if (take_cur) begin
        next_full_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      current_instruction_holding_register_q <= 16'h0000;
      dec_q                                  <= '0;
      addr_b_q                               <= ifd_pkg::UPC_RESET;
    end else if (take_cur) begin
      current_instruction_holding_register_q <=
        next_instruction_holding_register_q;
      dec_q    <= dec_bus.f;
      addr_b_q <= dec_bus.f.addr_b;
    end
  end

  // one register for both halves; a stack word reloads it for the right op
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      microprogram_address_register_q <= ifd_pkg::UPC_RESET;
      start_load_q                    <= 1'b0;
      active_op_q                     <= 6'h00;
    end else begin
      start_load_q <= take_cur || go_b;
      if (take_cur) begin
        microprogram_address_register_q <= dec_bus.f.addr_a;
        active_op_q <= dec_bus.f.sop_a;
      end else if (go_b) begin
        microprogram_address_register_q <= addr_b_q;
        active_op_q <= dec_q.sop_b;
      end else if (running && upc_step_i) begin
        microprogram_address_register_q <=
          microprogram_address_register_q + 11'h001;
      end
    end
  end

  assign irq_window_o      = (state_q == ST_IRQ);
  assign stack_phase_b_o   = (state_q == ST_RUN_B);
  assign cur_valid_o       = running || (state_q == ST_IRQ);
  assign cur_instr_o       = current_instruction_holding_register_q;
  assign start_load_o      = start_load_q;
  assign upc_o             = microprogram_address_register_q;
  assign active_stack_op_o = active_op_q;
  assign group_o           = dec_q.grp;
  assign lead_o            = dec_q.lead;
  assign sub_opcode_o      = dec_q.sub;
  assign mini_en_o         = dec_q.mini_en;
  assign mini_opcode_o     = dec_q.mini;
  assign index_o           = dec_q.xbit;
  assign indirect_o        = dec_q.xbit &&
                             (dec_q.grp == ifd_pkg::GRP_SUB1);
  assign count_o           = dec_q.cnt;
  assign disp_neg_o        = dec_q.disp_neg;
  assign disp_o            = dec_q.disp;
  assign move_sel_o        = dec_q.move_sel;
  assign move_code_o       = dec_q.move_code;
  assign base_data_o       = dec_q.base_data;
  assign sp_dec_o          = dec_q.sp_dec;
  assign special_o         = dec_q.special;
  assign imm_op_o          = dec_q.imm_op;
  assign imm_operand_o     = dec_q.imm;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_left_done;
    state_q == ST_RUN_A && group_o == ifd_pkg::GRP_STACK && exec_done_i;
  endsequence

  sequence s_right_loaded;
    state_q == ST_RUN_B && start_load_o && upc_o == $past(addr_b_q);
  endsequence

  start_from_table_a: assert property (
    take_cur && next_instruction_holding_register_q[15:12] == 4'h1 |=>
    upc_o == ifd_pkg::LUT_BASE[1] +
             ifd_pkg::UA_W'($past(next_instruction_holding_register_q[10:6])))
    else $error("group 1 start address wrong");

  upc_step_a: assert property (
    running && upc_step_i && !take_cur && !go_b |=>
    upc_o == $past(upc_o) + 11'h001)
    else $error("microprogram address did not step");

  lead_group_a: assert property (
    cur_instr_o[15:12] == 4'h0 && cur_valid_o |->
    group_o == ifd_pkg::GRP_STACK)
    else $error("stack group not decoded");

  sub_field_a: assert property (
    group_o == ifd_pkg::GRP_SUB1 |-> sub_opcode_o == cur_instr_o[10:6])
    else $error("group 1 sub-opcode misplaced");

  mini_enable_a: assert property (
    mini_en_o |-> cur_instr_o[11:8] == 4'h0 &&
    mini_opcode_o == cur_instr_o[7:4])
    else $error("mini opcode enable wrong");

  stack_order_a: assert property (
    s_left_done and (!irq_pending_i) |=> s_right_loaded)
    else $error("right stack op did not follow left");

  irq_gap_a: assert property (
    s_left_done and irq_pending_i |=> irq_window_o && !start_load_o)
    else $error("interrupt gap not opened");

  shift_count_a: assert property (
    group_o == ifd_pkg::GRP_SUB1 |->
    count_o == cur_instr_o[5:0] && index_o == cur_instr_o[11])
    else $error("shift or bit position field wrong");

  branch_disp_a: assert property (
    cur_valid_o |-> disp_o == cur_instr_o[4:0] &&
    disp_neg_o == cur_instr_o[5])
    else $error("branch displacement field wrong");

  move_fields_a: assert property (
    cur_valid_o |-> sp_dec_o == cur_instr_o[1:0] &&
    base_data_o == cur_instr_o[4])
    else $error("move base or decrement wrong");

  imm_fields_a: assert property (
    group_o == ifd_pkg::GRP_SUB3 |->
    imm_operand_o == cur_instr_o[7:0] && imm_op_o == cur_instr_o[11:8])
    else $error("immediate fields wrong");

  hold_next_a: assert property (
    cur_valid_o && !exec_done_i |=> $stable(cur_instr_o))
    else $error("current instruction replaced early");

  stack_left_a: assert property (
    take_cur && next_instruction_holding_register_q[15:12] == 4'h0 |=>
    active_stack_op_o == cur_instr_o[11:6] &&
    upc_o == ifd_pkg::LUT_BASE[0] + ifd_pkg::UA_W'(cur_instr_o[11:6]))
    else $error("left stack code or start address wrong");

  group_one_a: assert property (
    cur_valid_o && cur_instr_o[15:12] == 4'h1 |->
    group_o == ifd_pkg::GRP_SUB1 && sub_opcode_o == cur_instr_o[10:6])
    else $error("group 1 not selected by leading field");

  indirect_bit_a: assert property (
    cur_valid_o |->
    indirect_o == (cur_instr_o[15:12] == 4'h1 && cur_instr_o[11]))
    else $error("indirect bit wrong");

  bit_position_a: assert property (
    cur_valid_o |-> count_o == cur_instr_o[5:0] &&
    index_o == cur_instr_o[11])
    else $error("bit position or index bit wrong");

  move_select_a: assert property (
    cur_valid_o |-> move_sel_o == (cur_instr_o[15:7] == 9'h040) &&
    move_code_o == cur_instr_o[7:5])
    else $error("move selection wrong");

  special_code_a: assert property (
    cur_valid_o |-> special_o == {cur_instr_o[7:4], cur_instr_o[0]})
    else $error("special code wrong");

  next_hold_a: assert property (
    !fetch_ready_o && !take_cur |=>
    !fetch_ready_o && $stable(next_instruction_holding_register_q))
    else $error("waiting word lost or replaced");

  lead_field_a: assert property (
    cur_valid_o |-> lead_o == cur_instr_o[15:12])
    else $error("leading field bit order wrong");

endmodule // ifd_decoder

// *** ifd_fetch_model.sv ***
`timescale 1ns/1ps
module ifd_fetch_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        req_i,
  input  wire logic [15:0] word_i,
  input  wire logic        ready_i,
  output logic             valid_o,
  output logic [15:0]      word_o
);
  logic taken_q;

  // ready is judged on the same rising edge that takes the word
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      taken_q <= 1'b0;
    end else begin
      taken_q <= valid_o && ready_i;
    end
  end

  // word held until taken; released lines flip so stale data cannot pass
  always_ff @(negedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
      word_o  <= 16'h0000;
    end else if (taken_q) begin
      valid_o <= 1'b0;
      word_o  <= ~word_o;
    end else if (req_i && !valid_o) begin
      valid_o <= 1'b1;
      word_o  <= word_i;
    end
  end
endmodule // ifd_fetch_model

// *** test_instruction_format_decoder.sv ***
`timescale 1ns/1ps
module test_instruction_format_decoder;
  logic ref_clk_i, rst_i, req, exec_done_i, upc_step_i;
  logic irq_pending_i, irq_done_i, fetch_valid_i, fetch_ready_o;
  logic irq_window_o, cur_valid_o, start_load_o, stack_phase_b_o;
  logic mini_en_o, index_o, indirect_o, disp_neg_o, move_sel_o, base_data_o;
  logic [15:0]              req_word, fetch_word_i, cur_instr_o;
  logic [ifd_pkg::UA_W-1:0] upc_o;
  logic [5:0]               active_stack_op_o, count_o;
  logic [4:0]               sub_opcode_o, disp_o, special_o;
  logic [3:0]               lead_o, mini_opcode_o, imm_op_o;
  logic [2:0]               move_code_o;
  logic [1:0]               sp_dec_o;
  logic [7:0]               imm_operand_o;
  ifd_pkg::ifd_grp_t        group_o;
  int                       mismatches, cmp_count, i;
  logic [15:0]              tbl [9] = '{16'h1DAB, 16'h10D7, 16'h205B,
    16'h2091, 16'h37A5, 16'h24C3, 16'h30F0, 16'h5ABC, 16'hF001};

  ifd_decoder ifd_decoder_inst (.ref_clk_i, .rst_i, .fetch_valid_i,
    .fetch_word_i, .fetch_ready_o, .exec_done_i, .upc_step_i, .irq_pending_i,
    .irq_done_i, .irq_window_o, .cur_instr_o, .cur_valid_o, .start_load_o,
    .upc_o, .stack_phase_b_o, .active_stack_op_o, .group_o, .lead_o,
    .sub_opcode_o, .mini_en_o, .mini_opcode_o, .index_o, .indirect_o,
    .count_o, .disp_neg_o, .disp_o, .move_sel_o, .move_code_o, .base_data_o,
    .sp_dec_o, .special_o, .imm_op_o, .imm_operand_o);

  ifd_fetch_model ifd_fetch_model_inst (.clk_i(ref_clk_i), .rst_i(rst_i),
    .req_i(req), .word_i(req_word), .ready_i(fetch_ready_o),
    .valid_o(fetch_valid_i), .word_o(fetch_word_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk_v(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_g(input ifd_pkg::ifd_grp_t got,
                       input ifd_pkg::ifd_grp_t exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: group got %0d exp %0d", $time, got, exp);
    end
  endtask

  task automatic fetch(input logic [15:0] w);
    @(negedge ref_clk_i);
    req      <= 1'b1;
    req_word <= w;
    @(negedge ref_clk_i);
    req <= 1'b0;
  endtask

  task automatic done1;
    exec_done_i = 1'b1;
    @(negedge ref_clk_i);
    exec_done_i = 1'b0;
  endtask

  // start_load_o stands one cycle, so it is polled every cycle
  task automatic wait_load;
    int n;
    n = 0;
    while (start_load_o !== 1'b1 && n < 50) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n == 50) chk_v(16'h0000, 16'h0001, "no start load");
  endtask

  task automatic chk_word(input logic [15:0] w);
    logic [3:0]               ld;
    logic                     g23;
    logic [4:0]               sub;
    logic [ifd_pkg::UA_W-1:0] ua;
    ifd_pkg::ifd_grp_t        g;
    ld  = w[15:12];
    g23 = (ld == 4'h2) || (ld == 4'h3);
    case (ld)
      4'h0: g = ifd_pkg::GRP_STACK;
      4'h1: g = ifd_pkg::GRP_SUB1;
      4'h2: g = ifd_pkg::GRP_SUB2;
      4'h3: g = ifd_pkg::GRP_SUB3;
      default: g = ifd_pkg::GRP_DIRECT;
    endcase
    sub = (ld == 4'h1) ? w[10:6] : (g23 ? {1'b0, w[11:8]} : 5'h00);
    ua  = ifd_pkg::LUT_BASE[ld];
    if (ld == 4'h0) ua = ua + 11'(w[11:6]);
    else if (g23 && sub == 5'h00) ua = ua + ifd_pkg::MINI_OFFSET + 11'(w[7:4]);
    else if (ld == 4'h1 || g23) ua = ua + 11'(sub);
    chk_v(cur_instr_o, w, "instr");
    chk_v(16'(lead_o), 16'(ld), "lead");
    chk_g(group_o, g);
    chk_v(16'(sub_opcode_o), 16'(sub), "sub");
    chk_v(16'(mini_en_o), 16'(g23 && w[11:8] == 4'h0), "mini_en");
    chk_v(16'(mini_opcode_o), 16'(w[7:4]), "mini");
    chk_v(16'(index_o), 16'(w[11]), "index");
    chk_v(16'(indirect_o), 16'(w[11] && ld == 4'h1), "indir");
    chk_v(16'(count_o), 16'(w[5:0]), "count");
    chk_v(16'({disp_neg_o, disp_o}), 16'(w[5:0]), "disp");
    chk_v(16'(move_sel_o), 16'(w[15:7] == 9'h040), "mv");
    chk_v(16'(move_code_o), 16'(w[7:5]), "move");
    chk_v(16'(base_data_o), 16'(w[4]), "base");
    chk_v(16'(sp_dec_o), 16'(w[1:0]), "sp_dec");
    chk_v(16'(special_o), 16'({w[7:4], w[0]}), "special");
    chk_v(16'(imm_op_o), 16'(w[11:8]), "imm_op");
    chk_v(16'(imm_operand_o), 16'(w[7:0]), "imm");
    chk_v(16'(upc_o), 16'(ua), "start");
    upc_step_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    upc_step_i = 1'b0;
    chk_v(16'(upc_o), 16'(ua + 11'h003), "step");
    chk_v(16'(start_load_o), 16'h0000, "pulse");
  endtask

  // stack word: left code, optional interrupt gap, then right code
  task automatic run_stack(input logic [15:0] w, input logic irq);
    irq_pending_i = irq;
    fetch(w);
    wait_load;
    chk_word(w);
    chk_v(16'(active_stack_op_o), 16'(w[11:6]), "left");
    chk_v(16'(stack_phase_b_o), 16'h0000, "phase");
    done1;
    if (irq) begin
      chk_v(16'(irq_window_o), 16'h0001, "gap");
      done1;
      chk_v(16'(stack_phase_b_o), 16'h0000, "gap hold");
      irq_pending_i = 1'b0;
      irq_done_i = 1'b1;
      @(negedge ref_clk_i);
      irq_done_i = 1'b0;
    end
    wait_load;
    chk_v(16'(stack_phase_b_o), 16'h0001, "phase b");
    chk_v(16'(active_stack_op_o), 16'(w[5:0]), "right");
    chk_v(16'(upc_o), 16'(ifd_pkg::LUT_BASE[0]+11'(w[5:0])), "b");
    done1;
    chk_v(16'(cur_valid_o), 16'h0000, "idle");
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk_i);
    mismatches++;
    end_sim;
  end

  initial begin
    {rst_i, req, exec_done_i, upc_step_i, irq_pending_i, irq_done_i} = 6'h20;
    req_word = 16'h0000;
    mismatches = 0;
    cmp_count = 0;
    repeat (10) @(negedge ref_clk_i);
    rst_i = 1'b0;
    chk_v(16'(fetch_ready_o), 16'h0001, "ready");
    chk_v(16'(cur_valid_o), 16'h0000, "valid");
    chk_v(16'(upc_o), 16'h0000, "upc");
    chk_g(group_o, ifd_pkg::GRP_STACK);
    fetch(tbl[0]);
    wait_load;
    chk_word(tbl[0]);
    for (i = 1; i < 9; i++) begin
      fetch(tbl[i]);
      repeat (2) @(negedge ref_clk_i);
      chk_v(16'(fetch_ready_o), 16'h0000, "held");
      chk_v(cur_instr_o, tbl[i-1], "cur kept");
      done1;
      wait_load;
      chk_word(tbl[i]);
    end
    done1;
    chk_v(16'(cur_valid_o), 16'h0000, "idle");
    run_stack(16'h0A95, 1'b0);
    run_stack(16'h0FC1, 1'b1);
    end_sim;
  end
endmodule // test_instruction_format_decoder
